//--- design/ccap_consts.svh
`ifndef CCAP_CONSTS_SVH
`define CCAP_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define CCAP_IDX_MODE       12'h110
`define CCAP_IDX_FRAME      12'h112
`define CCAP_IDX_CMD        12'h114
`define CCAP_IDX_STATUS     12'h116

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define CCAP_MODE_RST       16'h0000
`define CCAP_MODE_MASK      16'h1589
`define CCAP_FRAME_RST      16'h0000
`define CCAP_FRAME_MASK     16'h00ff
`define CCAP_STATUS_RST     16'h0044

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define CCAP_MODE_ENABLE    0
`define CCAP_MODE_CLKDIS    3
`define CCAP_MODE_BT656     7

// ----------------------------------------------------------------
// Frame setting register fields
// ----------------------------------------------------------------
`define CCAP_FRM_INTEN      0
`define CCAP_FRM_INTPOL     1
`define CCAP_FRM_SAMP_LO    2
`define CCAP_FRM_SAMP_HI    4
`define CCAP_FRM_ALLFRM     5
`define CCAP_FRM_SINGLE     6
`define CCAP_FRM_INTCTL     7
`define CCAP_SAMP_RSVD      3'h7

// ----------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------
`define CCAP_CMD_SRST       0
`define CCAP_CMD_INTCLR     1
`define CCAP_CMD_START      2
`define CCAP_CMD_STOP       3
`define CCAP_CMD_ERR0CLR    8
`define CCAP_CMD_ERR1CLR    9

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define CCAP_ST_INT         1
`define CCAP_ST_STARTED     2
`define CCAP_ST_BUSY        3
`define CCAP_ST_EFFECTIVE   4
`define CCAP_ST_VSYNC       6
`define CCAP_ST_ERR0        8
`define CCAP_ST_ERR1        9

// ----------------------------------------------------------------
// Camera clock output timing
// ----------------------------------------------------------------
`define CCAP_CLKOUT_HALF_NS 20
`define CCAP_CLK_NS         5

`endif

//--- design/ccap_pkg.sv
// ----------------------------------------------------------------
// Types of the camera capture control block
// ----------------------------------------------------------------
package ccap_pkg;

  // Capture sequencer states
  typedef enum logic [1:0]
  {
    CCAP_IDLE,
    CCAP_ARMED,
    CCAP_CAPTURE
  } ccap_state_t;

endpackage

//--- design/ccap_sync.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ----------------------------------------------------------------
module ccap_sync
#(
  parameter int        WIDTH    = 1,
  parameter logic      RST_VAL  = 1'b0
)
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Asynchronous input and synchronised output
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;   // Metastability catcher, read only below

  // Two flops in series
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1  <= {WIDTH{RST_VAL}};
      syncOut <= {WIDTH{RST_VAL}};
    end
    else
    begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule

//--- design/ccap_frame_capture.sv
// Overview of operation
// - Clock-out disable bit holds camera clock low
// - Module enable gates camera logic and clock
// - Continuous, control set: interrupt after capture stops
// - Control set overrides all-frames interrupt setting
// - Single-frame bit clear: capture frames continuously
// - Single-frame bit set: capture one frame, stop
// - All-frames clear: flag only while encoder runs
// - All-frames set: flag on every captured frame
// - All-frames bit ignored while interrupts disabled
// - Sampling field decimates frames, 111b reserved
// - Polarity picks VSYNC active or inactive edge
// - Interrupt enable suppresses or permits interrupts
// - Error clear bits act only in BT656 mode
// - Stop command halts frame capture
// - Start command begins frame capture
// - Status clear command clears interrupt flag
// - Software reset reinitialises logic, keeps registers
// - Writing zero command bits does nothing
// - Two-bit reference error sets error flag 1
// - One-bit reference error sets error flag 0
// - BT656 enable selects embedded sync mode
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "ccap_consts.svh"

module ccap_frame_capture
#(
  parameter int ADDR_W = 12   // APB address width
)
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Camera pins
  input  wire logic              camVsync,
  output logic                   cameraClockOut,
  // On-chip sources
  input  wire logic              encoderStart,
  input  wire logic              refOneBitErr,
  input  wire logic              refTwoBitErr,
  // Interrupt
  output logic                   captureIrq
);

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_MODE   = ADDR_W'(`CCAP_IDX_MODE * 4);
  localparam logic [ADDR_W-1:0] ADDR_FRAME  = ADDR_W'(`CCAP_IDX_FRAME * 4);
  localparam logic [ADDR_W-1:0] ADDR_CMD    = ADDR_W'(`CCAP_IDX_CMD * 4);
  localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(`CCAP_IDX_STATUS * 4);
  localparam int  CLK_HALF_CYC = (`CCAP_CLKOUT_HALF_NS / `CCAP_CLK_NS) < 1 ? 1 :
                                 (`CCAP_CLKOUT_HALF_NS / `CCAP_CLK_NS);
  localparam logic [7:0] CLK_HALF_LAST = 8'(CLK_HALF_CYC - 1);
  localparam logic [15:0] STATUS_RST   = `CCAP_STATUS_RST;    // Status word after reset
  localparam logic        START_RST    = STATUS_RST[`CCAP_ST_STARTED]; // Start flag after reset

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [15:0]          modeReg;       // Camera mode setting
  logic [15:0]          frameReg;      // Camera frame setting
  ccap_pkg::ccap_state_t state;        // Capture sequencer
  ccap_pkg::ccap_state_t next_state;   // Next sequencer state
  logic                 startFlag;     // Start command in force
  logic                 effCur;        // Current frame is effective
  logic [2:0]           frameCnt;      // Decimation counter
  logic                 irqPending;    // Qualified frame awaits trigger edge
  logic                 intStatus;     // Sticky interrupt flag
  logic                 err0;          // One-bit reference error flag
  logic                 err1;          // Two-bit reference error flag
  logic                 vsSync;        // Synchronised VSYNC
  logic                 vsPrev;        // VSYNC one cycle earlier
  logic [7:0]           clkDivCnt;     // Camera clock divider
  logic                 clkToggle;     // Divided camera clock

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire access    = psel & penable;
  wire hitMode   = (paddr == ADDR_MODE);
  wire hitFrame  = (paddr == ADDR_FRAME);
  wire hitCmd    = (paddr == ADDR_CMD);
  wire hitStatus = (paddr == ADDR_STATUS);
  wire mapped    = hitMode | hitFrame | hitCmd | hitStatus;
  wire wrEn      = access & pwrite & mapped;
  wire wrCmd     = wrEn & hitCmd;

  // Command pulses, a zero bit yields none
  wire cmdSrst   = wrCmd & pwdata[`CCAP_CMD_SRST];
  wire cmdIntClr = wrCmd & pwdata[`CCAP_CMD_INTCLR];
  wire cmdStart  = wrCmd & pwdata[`CCAP_CMD_START];
  wire cmdStop   = wrCmd & pwdata[`CCAP_CMD_STOP];
  wire cmdErr0   = wrCmd & pwdata[`CCAP_CMD_ERR0CLR];
  wire cmdErr1   = wrCmd & pwdata[`CCAP_CMD_ERR1CLR];

  // ----------------------------------------------------------------
  // Field selection
  // ----------------------------------------------------------------
  wire       modEn     = modeReg[`CCAP_MODE_ENABLE];
  wire       clkDis    = modeReg[`CCAP_MODE_CLKDIS];
  wire       bt656En   = modeReg[`CCAP_MODE_BT656];
  wire       intEn     = frameReg[`CCAP_FRM_INTEN];
  wire       intPol    = frameReg[`CCAP_FRM_INTPOL];
  wire       allFrm    = frameReg[`CCAP_FRM_ALLFRM];
  wire       single    = frameReg[`CCAP_FRM_SINGLE];
  wire       intCtl    = frameReg[`CCAP_FRM_INTCTL];
  wire [2:0] sampField = frameReg[`CCAP_FRM_SAMP_HI:`CCAP_FRM_SAMP_LO];

  // Reserved sampling code treated as every frame
  wire [2:0] sampLast = (sampField == `CCAP_SAMP_RSVD) ? 3'h0 : sampField;
  wire       cntHit   = (frameCnt == 3'h0);
  wire [2:0] cntNext  = (frameCnt == sampLast) ? 3'h0 : frameCnt + 3'h1;

  // VSYNC edges
  wire vsRise = vsSync & ~vsPrev;
  wire vsFall = ~vsSync & vsPrev;

  // Logic held in reset while disabled or soft-reset
  wire logicRst = ~modEn | cmdSrst;

  // Frame end and capture completion
  wire frameEnd  = (state == ccap_pkg::CCAP_CAPTURE) & vsRise;
  wire frameDone = frameEnd & effCur;
  wire stopNow   = cmdStop | (frameEnd & single);

  // Interrupt qualification
  wire qualCtl  = single ? 1'b1 : ~startFlag;
  wire qualAll  = allFrm | encoderStart;
  wire qualSel  = intCtl ? qualCtl : qualAll;
  wire doneQual = frameDone & qualSel & intEn;
  wire trigEdge = intPol ? vsFall : vsRise;
  wire intSet   = intPol ? (trigEdge & (irqPending | doneQual))
                         : doneQual;

  // Error flag updates
  wire err0Set  = bt656En & refOneBitErr;
  wire err1Set  = bt656En & refTwoBitErr;
  wire err0Clr  = bt656En & cmdErr0;
  wire err1Clr  = bt656En & cmdErr1;

  // Status word
  wire [15:0] statusWord = {6'h00, err1, err0, 1'b0, vsSync, 1'b0, effCur,
                            (state == ccap_pkg::CCAP_CAPTURE), startFlag,
                            intStatus, 1'b0};

  // Read data selection
  wire [15:0] rdSel = hitMode   ? modeReg :
                      hitFrame  ? frameReg :
                      hitStatus ? statusWord : 16'h0000;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  ccap_sync
  #(
    .WIDTH   (1),
    .RST_VAL (1'b1)
  )
  u_vsync
  (
    .clock   (clock),
    .rst_n   (rst_n),
    .asyncIn (camVsync),
    .syncOut (vsSync)
  );

  // ----------------------------------------------------------------
  // APB answers
  // ----------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // Read data captured in setup cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= 32'h0000_0000;
    else if (psel & ~penable)
      prdata <= {16'h0000, rdSel};
  end

  // Software registers, untouched by soft reset
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      modeReg  <= `CCAP_MODE_RST;
      frameReg <= `CCAP_FRAME_RST;
    end
    else
    begin
      if (wrEn & hitMode)
        modeReg <= pwdata[15:0] & `CCAP_MODE_MASK;
      if (wrEn & hitFrame)
        frameReg <= pwdata[15:0] & `CCAP_FRAME_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Capture sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      ccap_pkg::CCAP_IDLE:
        if (startFlag & ~cmdStop)
          next_state = ccap_pkg::CCAP_ARMED;
      ccap_pkg::CCAP_ARMED:
        if (cmdStop)
          next_state = ccap_pkg::CCAP_IDLE;
        else if (vsRise)
          next_state = ccap_pkg::CCAP_CAPTURE;
      ccap_pkg::CCAP_CAPTURE:
        if (frameEnd & (single | ~startFlag))
          next_state = ccap_pkg::CCAP_IDLE;
      default:
        next_state = ccap_pkg::CCAP_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state <= ccap_pkg::CCAP_IDLE;
    else if (logicRst)
      state <= ccap_pkg::CCAP_IDLE;
    else
      state <= next_state;
  end

  // Start/stop flag, stop beats start in one write
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      startFlag <= START_RST;
    else if (cmdSrst)
      startFlag <= START_RST;
    else if (stopNow)
      startFlag <= 1'b0;
    else if (cmdStart)
      startFlag <= 1'b1;
  end

  // Frame decimation on each captured frame boundary
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frameCnt <= 3'h0;
      effCur   <= 1'b0;
    end
    else if (logicRst | (state == ccap_pkg::CCAP_IDLE))
    begin
      frameCnt <= 3'h0;
      effCur   <= 1'b0;
    end
    else if (vsRise & (next_state == ccap_pkg::CCAP_CAPTURE))
    begin
      effCur   <= cntHit;
      frameCnt <= cntNext;
    end
    else if (next_state != ccap_pkg::CCAP_CAPTURE)
      effCur   <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Interrupt flag
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irqPending <= 1'b0;
      intStatus  <= 1'b0;
    end
    else if (logicRst)
    begin
      irqPending <= 1'b0;
      intStatus  <= 1'b0;
    end
    else
    begin
      // Wait for inactive edge when polarity is set
      if (intPol & trigEdge)
        irqPending <= 1'b0;
      else if (intPol & doneQual)
        irqPending <= 1'b1;
      // Set wins over clear
      if (intSet)
        intStatus <= 1'b1;
      else if (cmdIntClr)
        intStatus <= 1'b0;
    end
  end

  assign captureIrq = intStatus & intEn;

  // ----------------------------------------------------------------
  // Reference decode error flags
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      err0 <= 1'b0;
      err1 <= 1'b0;
    end
    else if (logicRst)
    begin
      err0 <= 1'b0;
      err1 <= 1'b0;
    end
    else
    begin
      if (err0Set)
        err0 <= 1'b1;
      else if (err0Clr)
        err0 <= 1'b0;
      if (err1Set)
        err1 <= 1'b1;
      else if (err1Clr)
        err1 <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // VSYNC history and camera clock output
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      vsPrev <= 1'b1;
    else
      vsPrev <= vsSync;
  end

  // Divider runs only while the clock is allowed out
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clkDivCnt      <= 8'h00;
      clkToggle      <= 1'b0;
      cameraClockOut <= 1'b0;
    end
    else if (~modEn | clkDis)
    begin
      clkDivCnt      <= 8'h00;
      clkToggle      <= 1'b0;
      cameraClockOut <= 1'b0;
    end
    else
    begin
      if (clkDivCnt == CLK_HALF_LAST)
      begin
        clkDivCnt <= 8'h00;
        clkToggle <= ~clkToggle;
      end
      else
        clkDivCnt <= clkDivCnt + 8'h01;
      cameraClockOut <= clkToggle;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_clkBlocked;
    (~modEn | clkDis) [*2];
  endsequence

  property p_clkout_low;
    s_clkBlocked |-> !cameraClockOut;
  endproperty
  a_clkout_low: assert property (p_clkout_low)
    else $error("camera clock out not held low");

  property p_disabled_idle;
    !modEn |=> (state == ccap_pkg::CCAP_IDLE) && !intStatus;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("disabled module not idle");

  property p_irq_masked;
    !intEn |-> !captureIrq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt seen while disabled");

  property p_irq_sticky;
    intStatus && !cmdIntClr && !logicRst |=> intStatus && (captureIrq == intEn);
  endproperty
  a_irq_sticky: assert property (p_irq_sticky)
    else $error("interrupt flag dropped without clear");

  property p_int_clear;
    cmdIntClr && !intSet && !logicRst |=> !intStatus;
  endproperty
  a_int_clear: assert property (p_int_clear)
    else $error("interrupt flag not cleared");

  sequence s_stopWrite;
    cmdStop && !cmdSrst;
  endsequence

  property p_stop;
    s_stopWrite |=> !startFlag ##0 (state != ccap_pkg::CCAP_ARMED);
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop command ignored");

  property p_start;
    cmdStart && !cmdStop && !cmdSrst && modEn |=> startFlag ##1
      (state == ccap_pkg::CCAP_ARMED) || !modEn || cmdStop;
  endproperty
  a_start: assert property (p_start)
    else $error("start command ignored");

  property p_err0_set;
    err0Set && !logicRst |=> err0;
  endproperty
  a_err0_set: assert property (p_err0_set)
    else $error("one-bit error not flagged");

  property p_err1_set;
    err1Set && !logicRst |=> err1;
  endproperty
  a_err1_set: assert property (p_err1_set)
    else $error("two-bit error not flagged");

  property p_err_clear_gated;
    !bt656En && err0 && !logicRst |=> err0;
  endproperty
  a_err_clear_gated: assert property (p_err_clear_gated)
    else $error("error flag cleared outside BT656 mode");

  property p_single_stops;
    frameEnd && single && !logicRst |=> (state == ccap_pkg::CCAP_IDLE) && !startFlag;
  endproperty
  a_single_stops: assert property (p_single_stops)
    else $error("single frame capture did not stop");

  property p_zero_cmd;
    wrCmd && (pwdata[15:0] == 16'h0000) && !intSet && !stopNow |=>
      $stable(intStatus) && $stable(startFlag);
  endproperty
  a_zero_cmd: assert property (p_zero_cmd)
    else $error("zero command had an effect");

endmodule

//--- sim/ccap_cam_model.sv
`timescale 1ns/1ps

// Camera sensor: eight link clocks per frame, vsync high in second half
module ccap_cam_model
(
  // Frame request from the bench
  input  wire logic run,
  // Vsync pin towards the block
  output logic      camVsync
);
  logic       linkClk = 1'b0;  // Link clock, still outside frames
  logic [2:0] phase   = 3'h0;  // Position in the frame

  // Link clock, phase unrelated to the system clock
  initial
  begin
    #1.3;
    forever #40 linkClk = run ? ~linkClk : 1'b0;
  end

  // Frame position counter
  always @(posedge linkClk)
    phase <= phase + 3'h1;

  assign camVsync = phase[2];
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
`include "ccap_consts.svh"

module tb_top;
  logic        clock;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        camRun;
  logic        camVsync;
  logic        cameraClockOut;
  logic        encoderStart;
  logic        refOneBitErr;
  logic        refTwoBitErr;
  logic        captureIrq;
  logic [31:0] rdata;
  logic        rerr;
  int          err_count = 0;
  int          tests_run = 0;
  int          cycles    = 0;
  localparam logic [11:0] AM = `CCAP_IDX_MODE << 2;
  localparam logic [11:0] AF = `CCAP_IDX_FRAME << 2;
  localparam logic [11:0] AC = `CCAP_IDX_CMD << 2;
  localparam logic [11:0] AS = `CCAP_IDX_STATUS << 2;

  ccap_frame_capture dut
  (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .camVsync(camVsync), .cameraClockOut(cameraClockOut), .encoderStart(encoderStart),
    .refOneBitErr(refOneBitErr), .refTwoBitErr(refTwoBitErr), .captureIrq(captureIrq)
  );
  ccap_cam_model cam (.run(camRun), .camVsync(camVsync));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Hang guard
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      err_count++;
      results();
    end
  end

  task results;
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask

  // One APB transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input string n, input logic [11:0] a, input logic [15:0] m, input logic [15:0] e);
    apb(1'b0, a, 16'h0);
    chk(n, {16'h0, e}, rdata & {16'h0, m});
  endtask

  // Wait for vsync rises plus settling
  task vs(input int n);
    repeat (n) @(posedge camVsync);
    repeat (8) @(posedge clock);
  endtask

  task irq(input logic e);
    @(negedge clock);
    chk("captureIrq", {31'h0, e}, {31'h0, captureIrq});
  endtask

  task pulse(input logic two);
    if (two)
      refTwoBitErr <= 1'b1;
    else
      refOneBitErr <= 1'b1;
    @(posedge clock);
    if (two)
      refTwoBitErr <= 1'b0;
    else
      refOneBitErr <= 1'b0;
  endtask

  task tRegs;
    rd("mode", AM, 16'hffff, 16'h0000);
    rd("frame", AF, 16'hffff, 16'h0000);
    rd("status", AS, 16'hffbf, 16'h0004);
    rd("cmd", AC, 16'hffff, 16'h0000);
    apb(1'b0, 12'h460, 16'h0);
    chk("pslverr", 32'h1, {31'h0, rerr});
    apb(1'b1, AM, 16'hffff);
    rd("modeMask", AM, 16'hffff, `CCAP_MODE_MASK);
  endtask

  task tClk(input logic [15:0] m, input logic e);
    int   n;
    logic p;
    apb(1'b1, AM, m);
    repeat (2) @(posedge clock);
    @(negedge clock);
    n = 0;
    repeat (40)
    begin
      p = cameraClockOut;
      @(negedge clock);
      if (cameraClockOut !== p)
        n++;
    end
    chk("clockRuns", {31'h0, e}, {31'h0, n > 0});
    if (!e)
      chk("clockLow", 32'h0, {31'h0, cameraClockOut});
  endtask

  task tCont;
    apb(1'b1, AF, 16'h0021);
    camRun <= 1'b1;
    apb(1'b1, AC, 16'h0004);
    vs(3);
    irq(1'b1);
    rd("busyInt", AS, 16'h000a, 16'h000a);
    apb(1'b1, AC, 16'h0000);
    irq(1'b1);
    apb(1'b1, AC, 16'h0002);
    irq(1'b0);
    vs(1);
    irq(1'b1);
    apb(1'b1, AC, 16'h0008);
    vs(2);
    rd("busy", AS, 16'h0008, 16'h0000);
  endtask

  task tMask;
    apb(1'b1, AF, 16'h0020);
    apb(1'b1, AC, 16'h0006);
    vs(3);
    irq(1'b0);
    apb(1'b1, AF, 16'h0001);
    apb(1'b1, AC, 16'h0002);
    vs(2);
    irq(1'b0);
    encoderStart <= 1'b1;
    vs(2);
    irq(1'b1);
    encoderStart <= 1'b0;
    apb(1'b1, AF, 16'h0081);
    apb(1'b1, AC, 16'h0002);
    vs(3);
    irq(1'b0);
    apb(1'b1, AC, 16'h0008);
    vs(2);
    irq(1'b1);
  endtask

  task tPol;
    apb(1'b1, AF, 16'h0023);
    apb(1'b1, AC, 16'h0004);
    vs(2);
    @(negedge camVsync);
    repeat (8) @(posedge clock);
    apb(1'b1, AC, 16'h0002);
    vs(1);
    irq(1'b0);
    @(negedge camVsync);
    repeat (8) @(posedge clock);
    irq(1'b1);
  endtask

  task tSamp;
    int n;
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b1, AF, {10'h000, 1'b1, i[2:0], 2'b01});
      vs(1);
      n = 0;
      repeat (2 * (i + 1))
      begin
        apb(1'b1, AC, 16'h0002);
        vs(1);
        if (captureIrq === 1'b1)
          n++;
      end
      chk("sampledFrames", 32'h2, n);
    end
  endtask

  task tSingle;
    apb(1'b1, AC, 16'h0008);
    apb(1'b1, AM, 16'h0000);
    apb(1'b1, AF, 16'h0061);
    apb(1'b1, AM, 16'h0001);
    apb(1'b1, AC, 16'h0006);
    vs(3);
    irq(1'b1);
    rd("busy", AS, 16'h0008, 16'h0000);
    apb(1'b1, AC, 16'h0002);
    vs(2);
    irq(1'b0);
  endtask

  task tBt;
    apb(1'b1, AM, 16'h0081);
    pulse(1'b0);
    rd("err0", AS, 16'h0300, 16'h0100);
    pulse(1'b1);
    rd("err1", AS, 16'h0300, 16'h0300);
    apb(1'b1, AC, 16'h0001);
    rd("errSrst", AS, 16'h0300, 16'h0000);
    rd("modeKept", AM, 16'hffff, 16'h0081);
    pulse(1'b0);
    pulse(1'b1);
    apb(1'b1, AM, 16'h0001);
    apb(1'b1, AC, 16'h0300);
    apb(1'b1, AM, 16'h0081);
    rd("errKept", AS, 16'h0300, 16'h0300);
    apb(1'b1, AC, 16'h0100);
    rd("err0Clr", AS, 16'h0300, 16'h0200);
    apb(1'b1, AC, 16'h0200);
    rd("err1Clr", AS, 16'h0300, 16'h0000);
  endtask

  initial
  begin
    rst_n        = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 12'h000;
    pwdata       = 32'h0;
    camRun       = 1'b0;
    encoderStart = 1'b0;
    refOneBitErr = 1'b0;
    refTwoBitErr = 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    tRegs();
    tClk(16'h0000, 1'b0);
    tClk(16'h0001, 1'b1);
    tClk(16'h0009, 1'b0);
    apb(1'b1, AM, 16'h0001);
    tCont();
    tMask();
    tPol();
    tSamp();
    tSingle();
    tBt();
    results();
  end
endmodule
